/* hw/bilss_regs.sv */
// i/o limit and secondary status registers of the bridge, with the
// i/o window upper-bound compare used by the forwarding logic.
// assumes event inputs are single-cycle strobes from the secondary
// bus interface, synchronous to sys_clk; config access is byte wide.
`timescale 1ns/100ps

// Contract
// - limit field bits 7:4 are address 15:12
// - low twelve limit bits compare as ones
// - upper limit bits from register at 32h
// - limit bits 3:0 read 1h
// - addresses above limit are not forwarded
// - target address/attribute error sets bit 15
// - write-target or read-master data error sets 15
// - bit 15 ignores parity response enable
// - observed serr sets bit 14
// - mastered transaction master abort sets 13
// - received target abort sets bit 12
// - signaled target abort sets bit 11
// - bits 10:9 read 01b
// - bit 8 needs master, enable, perr
// - bit 7 reads 1b
// - bit 5 reads 1b
// - reserved bits ignore writes, read zero
module bilss_regs
   import bilss_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // configuration access
   input  wire logic        cfgWrite,
   input  wire logic        cfgRead,
   input  wire logic [7:0]  cfgAddr,
   input  wire logic [7:0]  cfgWriteData,
   output logic      [7:0]  cfgReadData,
   output logic             cfgReadValid,
   // secondary bus events
   input  wire logic        targetAddrParityErr,
   input  wire logic        targetWriteDataErr,
   input  wire logic        masterReadDataErr,
   input  wire logic        serrObserved,
   input  wire logic        masterAbortSeen,
   input  wire logic        targetAbortReceived,
   input  wire logic        targetAbortSignaled,
   input  wire logic        isBusMaster,
   input  wire logic        perrDrivenOnRead,
   input  wire logic        perrSeenOnWrite,
   // i/o forwarding check
   input  wire logic        ioCheckValid,
   input  wire logic [31:0] ioCheckAddr,
   output logic             ioBelowLimit,
   output logic             ioCheckDone,
   output logic [31:0]      ioLimitAddr
);

   // ****************************************
   // storage
   // ****************************************
   logic [3:0]  io_upper_bound_field;
   logic [7:0]  ioLimitUpperLo;
   logic [7:0]  ioLimitUpperHi;
   logic [15:0] ioLimitUpper16;
   logic        parity_response_enable;

   logic        wrIoBound;
   logic        wrUpperLo;
   logic        wrUpperHi;
   logic        wrBridgeCtl;
   logic        wrStatusLo;
   logic        wrStatusHi;

   logic        parityHit;
   logic        systemHit;
   logic        mabortHit;
   logic        tabortRxHit;
   logic        tabortTxHit;
   logic        dataParHit;

   logic [15:0] errorFlags;
   logic [15:0] next_errorFlags;
   logic [15:0] flagSet;
   logic [15:0] flagClear;
   logic [15:0] statusFixed;
   logic [15:0] statusWord;
   logic [7:0]  next_cfgReadData;
   logic [31:0] next_ioLimitAddr;
   logic        next_ioBelowLimit;

   // ****************************************
   // write decode
   // ****************************************
   // one strobe per offset, shared by stores and clears
   always_comb begin
      wrIoBound   = cfgWrite && (cfgAddr == OFS_IO_WINDOW_UPPER_BOUND);
      wrUpperLo   = cfgWrite && (cfgAddr == OFS_IO_LIMIT_UPPER16_LO);
      wrUpperHi   = cfgWrite && (cfgAddr == OFS_IO_LIMIT_UPPER16_HI);
      wrBridgeCtl = cfgWrite && (cfgAddr == OFS_BRIDGE_CONTROL);
      wrStatusLo  = cfgWrite && (cfgAddr == OFS_SEC_BUS_ERROR_FLAGS_LO);
      wrStatusHi  = cfgWrite && (cfgAddr == OFS_SEC_BUS_ERROR_FLAGS_HI);
   end

   // ****************************************
   // i/o window limit field
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         io_upper_bound_field <= IO_UPPER_BOUND_RESET;
      end else if (wrIoBound) begin
         // low nibble is the fixed width code, never stored
         io_upper_bound_field <= cfgWriteData[7:4];
      end
   end

   // ****************************************
   // upper limit bytes
   // ****************************************
   // bytes kept apart so each has a single writer
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ioLimitUpperLo <= IO_LIMIT_UPPER16_RESET[7:0];
      end else if (wrUpperLo) begin
         ioLimitUpperLo <= cfgWriteData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ioLimitUpperHi <= IO_LIMIT_UPPER16_RESET[15:8];
      end else if (wrUpperHi) begin
         ioLimitUpperHi <= cfgWriteData;
      end
   end

   // no atomicity: a half-written upper limit is used as it stands
   always_comb begin
      ioLimitUpper16 = {ioLimitUpperHi, ioLimitUpperLo};
   end

   // ****************************************
   // bridge control
   // ****************************************
   // only the enable bit is kept; other bits read zero
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         parity_response_enable <= PARITY_RESPONSE_RESET;
      end else if (wrBridgeCtl) begin
         parity_response_enable <=
            cfgWriteData[PARITY_RESPONSE_ENABLE_BIT];
      end
   end

   // ****************************************
   // event qualification
   // ****************************************
   // enable deliberately not consulted for bit 15
   always_comb begin
      parityHit = targetAddrParityErr
                | targetWriteDataErr
                | masterReadDataErr;
      systemHit = serrObserved;
      mabortHit = masterAbortSeen;
      tabortRxHit = targetAbortReceived;
      tabortTxHit = targetAbortSignaled;
      dataParHit = isBusMaster
                 & parity_response_enable
                 & (perrDrivenOnRead | perrSeenOnWrite);
   end

   always_comb begin
      flagSet = 16'h0000;
      flagSet[FLAG_DETECTED_PARITY] = parityHit;
      flagSet[FLAG_RECEIVED_SYSTEM] = systemHit;
      flagSet[FLAG_RECEIVED_RECEIVED_MASTER_ABORT_FLAG] = mabortHit;
      flagSet[FLAG_RECEIVED_TABORT] = tabortRxHit;
      flagSet[FLAG_SIGNALED_TABORT] = tabortTxHit;
      flagSet[FLAG_MASTER_DATA_PAR] = dataParHit;
   end

   // ****************************************
   // write-one-to-clear
   // ****************************************
   always_comb begin
      flagClear = 16'h0000;
      if (wrStatusLo) begin
         flagClear[7:0] = cfgWriteData;
      end
      if (wrStatusHi) begin
         flagClear[15:8] = cfgWriteData;
      end
   end

   // ****************************************
   // sticky error flags
   // ****************************************
   // one cell per status bit; unmasked bits never hold a one
   generate
      for (genvar b = 0; b < 16; b++) begin : g_flag
         always_comb begin
            if (!ERROR_FLAG_MASK[b]) begin
               next_errorFlags[b] = 1'h0;
            end else if (flagSet[b]) begin
               // a set in the clearing cycle must not be lost
               next_errorFlags[b] = 1'h1;
            end else if (flagClear[b]) begin
               next_errorFlags[b] = 1'h0;
            end else begin
               next_errorFlags[b] = errorFlags[b];
            end
         end

         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               errorFlags[b] <= ERROR_FLAGS_RESET[b];
            end else begin
               errorFlags[b] <= next_errorFlags[b];
            end
         end
      end
   endgenerate

   // ****************************************
   // fixed status bits
   // ****************************************
   always_comb begin
      statusFixed = 16'h0000;
      statusFixed[10:9] = DEVSEL_MEDIUM;
      statusFixed[7] = FAST_BACK_TO_BACK_CAPABLE;
      statusFixed[5] = HIGH_SPEED_BUS_CAPABLE;
   end

   // reserved bits read zero whatever was written
   generate
      for (genvar s = 0; s < 16; s++) begin : g_status
         always_comb begin
            if (ERROR_FLAG_MASK[s]) begin
               statusWord[s] = errorFlags[s];
            end else begin
               statusWord[s] = statusFixed[s];
            end
         end
      end
   endgenerate

   // ****************************************
   // read strobe
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cfgReadValid <= STROBE_RESET;
      end else begin
         cfgReadValid <= cfgRead;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   // data follows the offset every cycle; reads have no side effect
   always_comb begin
      next_cfgReadData = READ_DATA_RESET;
      unique case (cfgAddr)
         OFS_IO_WINDOW_UPPER_BOUND: begin
            next_cfgReadData = {io_upper_bound_field,
                                IO_WIDTH_CODE};
         end
         OFS_SEC_BUS_ERROR_FLAGS_LO: begin
            next_cfgReadData = statusWord[7:0];
         end
         OFS_SEC_BUS_ERROR_FLAGS_HI: begin
            next_cfgReadData = statusWord[15:8];
         end
         OFS_IO_LIMIT_UPPER16_LO: begin
            next_cfgReadData = ioLimitUpperLo;
         end
         OFS_IO_LIMIT_UPPER16_HI: begin
            next_cfgReadData = ioLimitUpperHi;
         end
         OFS_BRIDGE_CONTROL: begin
            next_cfgReadData = {7'h00, parity_response_enable};
         end
         default: begin
            next_cfgReadData = READ_DATA_RESET;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cfgReadData <= READ_DATA_RESET;
      end else begin
         cfgReadData <= next_cfgReadData;
      end
   end

   // ****************************************
   // i/o window upper bound
   // ****************************************
   always_comb begin
      next_ioLimitAddr = {ioLimitUpper16, io_upper_bound_field,
                          IO_LIMIT_LOW_ONES};
   end

   // an address equal to the limit is still inside the window
   always_comb begin
      next_ioBelowLimit = ioCheckValid
                        && (ioCheckAddr <= next_ioLimitAddr);
   end

   // ****************************************
   // registered compare results
   // ****************************************
   // one cycle of latency keeps every output registered
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ioLimitAddr <= {IO_LIMIT_UPPER16_RESET, IO_UPPER_BOUND_RESET,
                         IO_LIMIT_LOW_ONES};
      end else begin
         ioLimitAddr <= next_ioLimitAddr;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ioCheckDone <= STROBE_RESET;
      end else begin
         ioCheckDone <= ioCheckValid;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ioBelowLimit <= STROBE_RESET;
      end else begin
         ioBelowLimit <= next_ioBelowLimit;
      end
   end

endmodule : bilss_regs

/* pkg/bilss_pkg.sv */
// constants for the bridge i/o limit and secondary status registers
// assumes byte-wide configuration accesses at the printed offsets
package bilss_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] OFS_IO_WINDOW_UPPER_BOUND      = 8'h1d;
   localparam logic [7:0] OFS_SEC_BUS_ERROR_FLAGS_LO     = 8'h1e;
   localparam logic [7:0] OFS_SEC_BUS_ERROR_FLAGS_HI     = 8'h1f;
   localparam logic [7:0] OFS_IO_LIMIT_UPPER16_LO        = 8'h32;
   localparam logic [7:0] OFS_IO_LIMIT_UPPER16_HI        = 8'h33;
   localparam logic [7:0] OFS_BRIDGE_CONTROL             = 8'h3e;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam logic [3:0] IO_WIDTH_CODE                  = 4'h1;
   localparam logic [3:0] IO_UPPER_BOUND_RESET           = 4'h0;
   localparam logic [15:0] IO_LIMIT_UPPER16_RESET        = 16'h0000;
   localparam logic [11:0] IO_LIMIT_LOW_ONES             = 12'hfff;
   localparam logic [1:0] DEVSEL_MEDIUM                  = 2'h1;
   localparam logic       FAST_BACK_TO_BACK_CAPABLE      = 1'h1;
   localparam logic       HIGH_SPEED_BUS_CAPABLE         = 1'h1;
   localparam int         PARITY_RESPONSE_ENABLE_BIT     = 0;
   localparam logic       PARITY_RESPONSE_RESET          = 1'h0;
   localparam logic [15:0] ERROR_FLAGS_RESET             = 16'h0000;
   localparam logic [7:0] READ_DATA_RESET                = 8'h00;
   localparam logic       STROBE_RESET                   = 1'h0;

   // error flag positions inside the secondary status word
   localparam int FLAG_DETECTED_PARITY = 15;
   localparam int FLAG_RECEIVED_SYSTEM = 14;
   localparam int FLAG_RECEIVED_RECEIVED_MASTER_ABORT_FLAG = 13;
   localparam int FLAG_RECEIVED_TABORT = 12;
   localparam int FLAG_SIGNALED_TABORT = 11;
   localparam int FLAG_MASTER_DATA_PAR = 8;
   localparam logic [15:0] ERROR_FLAG_MASK = 16'hf900;

endpackage : bilss_pkg

/* verification/bilss_bus_model.sv */
// secondary bus side: strobes the event lines of the bridge
// assumes the bench asks for one event pattern at a time
`timescale 1ns/100ps
module bilss_bus_model (
   input  wire logic       sys_clk,
   output logic      [9:0] ev
);
   initial ev = 10'h000;
   // single-cycle strobes; a level would keep re-setting flags
   task automatic fire(input logic [9:0] v);
      @(negedge sys_clk) ev = v;
      @(negedge sys_clk) ev = 10'h000;
   endtask : fire
endmodule : bilss_bus_model

/* verification/bilss_regs_sva.sv */
// checker for the i/o limit and secondary status registers
// assumes read data is registered from cfgAddr every cycle
`timescale 1ns/100ps
module bilss_regs_sva (
   input wire logic        sys_clk, reset_n, cfgWrite,
   input wire logic [7:0]  cfgAddr, cfgWriteData, cfgReadData,
   input wire logic        serrObserved, masterAbortSeen,
   input wire logic        targetAddrParityErr, targetWriteDataErr,
   input wire logic        masterReadDataErr, targetAbortReceived,
   input wire logic        targetAbortSignaled, ioCheckValid,
   input wire logic        ioBelowLimit,
   input wire logic [31:0] ioCheckAddr, ioLimitAddr
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_low_ones: assert property (ioLimitAddr[11:0] == 12'hfff)
      else $error("limit low bits");
   a_below_cmp: assert property (ioCheckValid |=>
      ioBelowLimit == ($past(ioCheckAddr) <= ioLimitAddr)) else $error("cmp");
   a_type_code: assert property (cfgAddr == 8'h1d |=>
      cfgReadData[3:0] == 4'h1) else $error("io type");
   a_status_fixed: assert property (cfgAddr == 8'h1e |=>
      cfgReadData == 8'ha0) else $error("status low byte");
   a_serr_flag: assert property (serrObserved ##1 cfgAddr == 8'h1f
      |=> cfgReadData[6]) else $error("serr flag");
   a_parity_flag: assert property ((targetAddrParityErr ||
      targetWriteDataErr || masterReadDataErr) ##1 cfgAddr == 8'h1f
      |=> cfgReadData[7] && cfgReadData[2:1] == 2'h1) else $error("par");
   a_abort_flags: assert property (cfgAddr == 8'h1f |=>
      (cfgReadData[5:3] | ~$past({masterAbortSeen, targetAbortReceived,
      targetAbortSignaled}, 2)) == 3'h7) else $error("abort flags");
   a_flag_clear: assert property (cfgWrite && cfgAddr == 8'h1f &&
      cfgWriteData[6] && !serrObserved ##1 cfgAddr == 8'h1f
      |=> !cfgReadData[6]) else $error("flag clear");
endmodule : bilss_regs_sva
bind bilss_regs bilss_regs_sva chk (.*);

/* verification/bilss_regs_tb_top.sv */
// self-checking bench for the bridge limit and status registers
// assumes bilss_bus_model drives the secondary bus events
`timescale 1ns/100ps
module bilss_regs_tb_top;
   logic        sys_clk = 0, reset_n = 0, cfgWrite = 0, cfgRead = 0;
   logic [7:0]  cfgAddr = 0, cfgWriteData = 0, cfgReadData;
   logic        cfgReadValid, ioCheckValid = 0, ioBelowLimit, ioCheckDone;
   logic [31:0] ioCheckAddr = 0, ioLimitAddr, lim;
   logic [9:0]  ev, v;
   logic        en;
   logic [7:0]  adr [4] = '{8'h1d, 8'h1e, 8'h1f, 8'h40};
   logic [7:0]  rv [8] = '{1, 8'ha0, 2, 0, 8'hf1, 8'ha0, 2, 0};
   int          seed = 56306, errors = 0, checks = 0, cyc = 0;
   always #12.5 sys_clk = ~sys_clk;
   bilss_bus_model bm (.sys_clk(sys_clk), .ev(ev));
   bilss_regs uut (.*, .targetAddrParityErr(ev[9]),
      .targetWriteDataErr(ev[8]), .masterReadDataErr(ev[7]),
      .serrObserved(ev[6]), .masterAbortSeen(ev[5]),
      .targetAbortReceived(ev[4]), .targetAbortSignaled(ev[3]),
      .isBusMaster(ev[2]), .perrDrivenOnRead(ev[1]),
      .perrSeenOnWrite(ev[0]));
   task automatic chk(input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, w);
      @(negedge sys_clk) {cfgWrite, cfgAddr, cfgWriteData} = {1'b1, a, w};
      @(negedge sys_clk) cfgWrite = 0;
   endtask : wr
   task automatic rdc(input logic [7:0] a, e);
      @(negedge sys_clk) {cfgRead, cfgAddr} = {1'b1, a};
      @(negedge sys_clk) cfgRead = 0;
      chk(cfgReadValid, 1);
      chk(cfgReadData, e);
   endtask : rdc
   task automatic io(input logic [31:0] a);
      @(negedge sys_clk) {ioCheckValid, ioCheckAddr} = {1'b1, a};
      @(negedge sys_clk) ioCheckValid = 0;
      chk(ioCheckDone, 1);
      chk(ioBelowLimit, a <= lim);
      chk(ioLimitAddr, lim);
   endtask : io
   // high status byte: parity, serr, aborts, devsel 01, data parity
   function automatic logic [7:0] flags(input logic [9:0] f, input logic e);
      return {|f[9:7], f[6:3], 2'b01, f[2] & e & (|f[1:0])};
   endfunction : flags
   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      repeat (8) @(negedge sys_clk);
      reset_n = 1;
      for (int j = 0; j < 8; j++) begin
         if (j == 4)
            for (int k = 0; k < 4; k++) wr(adr[k], k == 2 ? 0 : 8'hff);
         rdc(adr[j % 4], rv[j]);
      end
      // lone events first, then mixed patterns
      for (int i = 0; i < 30; i++) begin
         v = i < 10 ? 10'h001 << i : 10'($random(seed));
         en = i < 10 ? 1'b1 : 1'($random(seed));
         wr(8'h3e, {7'h00, en});
         wr(8'h1f, 8'hf9);
         bm.fire(i < 10 && i > 1 ? v | 10'h004 : v);
         if (i < 10 && i > 1) v = v | 10'h004;
         rdc(8'h1f, flags(v, en));
         wr(8'h1f, 8'h00);
         rdc(8'h1f, flags(v, en));
      end
      for (int i = 0; i < 12; i++) begin
         lim = {16'($random(seed)), 4'($random(seed)), 12'hfff};
         if (i == 0) lim = 32'hffffffff;
         wr(8'h32, lim[23:16]);
         wr(8'h33, lim[31:24]);
         wr(8'h1d, {lim[15:12], 4'h0});
         io(lim);
         io(lim + 1);
         io(32'($random(seed)));
         rdc(8'h32, lim[23:16]);
      end
      conclude();
   end
endmodule : bilss_regs_tb_top
